//--- bench/sadc_afe_model.sv
// sadc_afe_model: switch tree and comparator behind the front-end pins
// assumes: one-hot select; each input given as a code-equivalent level
module sadc_afe_model (
    // front end
    input wire sadc_pkg::sadc_sel_t  mux_sel_i,
    input wire sadc_pkg::sadc_code_t dac_code_i,
    input wire logic [63:0]          level_i,
    output logic                     cmp_hi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sadc_pkg::*;
    // high when input at or above trial
    always_comb begin
        cmp_hi_o = 1'b0;
        for (int n = 0; n < 8; n++) begin
            if (mux_sel_i[n]) cmp_hi_o = (dac_code_i <= level_i[n*8 +: 8]);
        end
    end
endmodule : sadc_afe_model

//--- bench/sadc_props.sv
// sadc_props: port checks of the converter control
// assumes: bound to sadc_top, single clk_i domain
module sadc_props (
    // clock and reset
    input wire logic                 clk_i,
    input wire logic                 sys_rst_i,
    // host pins
    input wire sadc_pkg::sadc_chan_t chan_sel_i,
    input wire logic                 addr_latch_i,
    input wire logic                 conv_start_i,
    input wire logic                 out_en_i,
    input wire sadc_pkg::sadc_code_t data_o,
    input wire logic                 data_oe_o,
    input wire logic                 conv_done_o,
    // front end
    input wire sadc_pkg::sadc_sel_t  mux_sel_o,
    input wire sadc_pkg::sadc_code_t dac_code_o,
    input wire logic                 cmp_hi_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import sadc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // =========================================
    // cycles since start fell, frozen once done is up
    logic [9:0] run_reg;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || conv_start_i) begin
            run_reg <= 10'h000;
        end else if (!conv_done_o) begin
            run_reg <= run_reg + 10'h001;
        end
    end
    sequence s_rise; $rose(conv_start_i); endsequence
    sequence s_fall; $fell(conv_start_i); endsequence
    property p_latch; $rose(addr_latch_i) |=> mux_sel_o == (8'h01 << $past(chan_sel_i)); endproperty
    property p_hold; !$rose(addr_latch_i) |=> $stable(mux_sel_o); endproperty
    property p_clear; s_rise |=> !conv_done_o && dac_code_o == 8'h00; endproperty
    property p_abort; s_rise |=> $stable(data_o); endproperty
    property p_begin; s_fall |=> dac_code_o == 8'h80; endproperty
    property p_wait; conv_start_i && $past(conv_start_i) |-> dac_code_o == 8'h00; endproperty
    property p_oe; data_oe_o == out_en_i; endproperty
    property p_load; $rose(conv_done_o) |-> $stable(data_o); endproperty
    property p_steps; $rose(conv_done_o) |-> run_reg >= 10'h12C && run_reg <= 10'h1A4; endproperty
    a_latch: assert property (p_latch) else $error("channel select wrong");
    a_hold: assert property (p_hold) else $error("select moved");
    a_clear: assert property (p_clear) else $error("start rise no clear");
    a_abort: assert property (p_abort) else $error("abort lost result");
    a_begin: assert property (p_begin) else $error("no msb trial");
    a_wait: assert property (p_wait) else $error("ran while start high");
    a_oe: assert property (p_oe) else $error("enable mismatch");
    a_load: assert property (p_load) else $error("result late");
    a_steps: assert property (p_steps) else $error("conversion length");
endmodule : sadc_props

bind sadc_top sadc_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .chan_sel_i(chan_sel_i), .addr_latch_i(addr_latch_i), .conv_start_i(conv_start_i),
    .out_en_i(out_en_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .conv_done_o(conv_done_o), .mux_sel_o(mux_sel_o), .dac_code_o(dac_code_o),
    .cmp_hi_i(cmp_hi_i));

//--- bench/tb_top.sv
// tb_top: self-checking bench of the converter control
// assumes: comparator model behind the front end; 25 MHz clock
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sadc_pkg::*;
    typedef struct { sadc_chan_t ch; sadc_code_t exp; } sadc_row_t;
    // channel n holds byte n; result equals the level code
    localparam logic [63:0] LVL = 64'hFE01AA557F80FF00;
    // last row leaves a non-zero result, so an abort that clobbers it is visible
    sadc_row_t rows [8] = '{'{3'h0, 8'h00}, '{3'h6, 8'h01}, '{3'h5, 8'hAA}, '{3'h4, 8'h55},
                            '{3'h3, 8'h7F}, '{3'h2, 8'h80}, '{3'h1, 8'hFF}, '{3'h7, 8'hFE}};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ale = 1'b0;
    logic ext_start = 1'b0;
    logic free_run = 1'b0;
    logic out_en = 1'b0;
    logic cmp_hi;
    logic data_oe;
    logic conv_done;
    sadc_chan_t chan = 3'h0;
    sadc_code_t data;
    sadc_code_t dac;
    sadc_sel_t mux;
    logic [7:0] rises;
    logic done_prev;
    int fails = 0;
    int check_count = 0;

    sadc_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .chan_sel_i(chan),
        .addr_latch_i(ale), .conv_start_i(ext_start | (free_run & conv_done)),
        .out_en_i(out_en), .data_o(data), .data_oe_o(data_oe), .conv_done_o(conv_done),
        .mux_sel_o(mux), .dac_code_o(dac), .cmp_hi_i(cmp_hi));
    sadc_afe_model u_afe (.mux_sel_i(mux), .dac_code_i(dac), .level_i(LVL), .cmp_hi_o(cmp_hi));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic latch(input sadc_chan_t ch);
        @(posedge clk_i) chan <= ch;
        ale <= 1'b1;
        @(posedge clk_i) ale <= 1'b0;
        @(negedge clk_i);
        chk8(mux, 8'h01 << ch);
    endtask : latch

    task automatic start();
        @(posedge clk_i) ext_start <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk1(conv_done, 1'b0);
        chk8(dac, 8'h00);
        @(posedge clk_i) ext_start <= 1'b0;
    endtask : start

    task automatic wait_done();
        for (int n = 0; n < 500 && conv_done !== 1'b1; n++) @(negedge clk_i);
        chk1(conv_done, 1'b1);
    endtask : wait_done

    task automatic read_chk(input logic [7:0] exp);
        @(posedge clk_i) out_en <= 1'b1;
        @(negedge clk_i);
        chk8(data, exp);
        chk1(data_oe, 1'b1);
        @(posedge clk_i) out_en <= 1'b0;
        @(negedge clk_i);
        chk1(data_oe, 1'b0);
    endtask : read_chk

    task automatic final_report();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk1(conv_done, 1'b1);
        chk8(mux, 8'h01);
        chk8(data, 8'h00);
        foreach (rows[i]) begin
            latch(rows[i].ch);
            start();
            wait_done();
            read_chk(rows[i].exp);
        end
        // abort mid-run: the restart must convert the new channel only
        latch(3'h1);
        start();
        repeat (150) @(posedge clk_i);
        latch(3'h6);
        start();
        @(negedge clk_i);
        chk8(data, rows[7].exp);
        wait_done();
        read_chk(8'h01);
        // feedback loop: switching it in gives the kick, two completions fit
        rises = 8'h00;
        done_prev = 1'b1;
        // kick: done idles high, so the or-ed start rises as the loop closes
        @(posedge clk_i) free_run <= 1'b1;
        repeat (900) begin
            @(negedge clk_i);
            if (conv_done === 1'b1 && done_prev === 1'b0) rises++;
            done_prev = conv_done;
        end
        chk8(rises, 8'h02);
        @(posedge clk_i) free_run <= 1'b0;
        read_chk(8'h01);
        // mid-run reset while the last looped conversion is still busy
        chk1(conv_done, 1'b0);
        // held three edges so done has settled before the checker wakes again
        @(posedge clk_i) sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk1(conv_done, 1'b1);
        chk8(mux, 8'h01);
        chk8(dac, 8'h00);
        chk8(data, 8'h00);
        final_report();
    end
endmodule : tb_top

//--- inc/sadc_cfg.svh
// sadc_cfg.svh: clock rates, reset values and timing counts of the converter control
// assumes: included by bare name from every design file that needs a figure
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// =====================================================================
// clocking
`define SADC_SYS_CLK_HZ   25000000
`define SADC_CONV_CLK_HZ  640000
// system clocks per conversion clock; integer division, so the step runs slightly fast
`define SADC_CONV_DIV     (`SADC_SYS_CLK_HZ / `SADC_CONV_CLK_HZ)
`define SADC_DIV_W        6

// =====================================================================
// result and selection
`define SADC_CODE_RST     8'h00
`define SADC_MSB_MASK     8'h80
`define SADC_CHAN_RST     3'h0
`define SADC_EOC_RST      1'b1

`endif

//--- inc/sadc_pkg.sv
// sadc_pkg: types shared by the converter control modules
// assumes: widths fixed at 8 result bits and 8 channels
package sadc_pkg;

    // =====================================================================
    // data types
    typedef logic [7:0] sadc_code_t;
    typedef logic [2:0] sadc_chan_t;
    typedef logic [7:0] sadc_sel_t;
    typedef logic [5:0] sadc_div_t;

    // =====================================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARMED = 4'h2,
        ST_CONV  = 4'h4,
        ST_LOAD  = 4'h8
    } sadc_state_t;

    // =====================================================================
    // module state records
    typedef struct packed {
        logic        ale_prev;
        logic        sc_prev;
        sadc_chan_t  chan;
        sadc_state_t state;
        sadc_code_t  result;
        logic        eoc;
    } sadc_top_st_t;

    typedef struct packed {
        sadc_code_t sar;
        sadc_code_t mask;
        logic       busy;
        logic       done;
    } sadc_sar_st_t;

    typedef struct packed {
        sadc_div_t cnt;
        logic      tick;
    } sadc_div_st_t;

endpackage : sadc_pkg

//--- inc/sadc_sar_if.sv
// sadc_sar_if: control and result signals between sequencer and approximation register
// assumes: all signals in the clk_i domain
interface sadc_sar_if;
    import sadc_pkg::*;

    logic       clear;
    logic       go;
    logic       tick;
    logic       cmp_hi;
    logic       done;
    logic       busy;
    sadc_code_t code;

    modport ctrl (output clear, output go, output tick, output cmp_hi,
                  input done, input busy, input code);
    modport sar  (input clear, input go, input tick, input cmp_hi,
                  output done, output busy, output code);
endinterface : sadc_sar_if

//--- src/sadc_clkdiv.sv
// sadc_clkdiv: makes the one-cycle conversion clock enable from clk_i
// assumes: free running from reset, never restarted by a conversion
`include "sadc_cfg.svh"
module sadc_clkdiv (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // enable
    output logic      tick_o
);
    import sadc_pkg::*;

    localparam sadc_div_t DIV_LAST = `SADC_DIV_W'(`SADC_CONV_DIV - 1);

    sadc_div_st_t st_reg;
    sadc_div_st_t st_next;

    // =====================================================================
    // divider
    always_comb begin
        st_next      = st_reg;
        st_next.tick = (st_reg.cnt == DIV_LAST);
        if (st_reg.cnt == DIV_LAST) begin
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;
endmodule : sadc_clkdiv

//--- src/sadc_sar.sv
// sadc_sar: the successive-approximation register, one decision per conversion tick
// assumes: cmp_hi is high when the selected input lies at or above the trial code
`include "sadc_cfg.svh"
module sadc_sar (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // sequencer side
    sadc_sar_if.sar   sar_if
);
    import sadc_pkg::*;

    sadc_sar_st_t st_reg;
    sadc_sar_st_t st_next;

    // =====================================================================
    // approximation steps
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (sar_if.clear) begin
            st_next.sar  = `SADC_CODE_RST;
            st_next.mask = `SADC_CODE_RST;
            st_next.busy = 1'b0;
        end else if (sar_if.go) begin
            // trial begins with the top bit set
            st_next.sar  = `SADC_MSB_MASK;
            st_next.mask = `SADC_MSB_MASK;
            st_next.busy = 1'b1;
        end else if (st_reg.busy && sar_if.tick) begin
            if (!sar_if.cmp_hi) begin
                st_next.sar = st_reg.sar & ~st_reg.mask;
            end
            st_next.mask = st_reg.mask >> 1;
            st_next.sar  = st_next.sar | (st_reg.mask >> 1);
            if (st_reg.mask[0]) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sar_if.code = st_reg.sar;
    assign sar_if.busy = st_reg.busy;
    assign sar_if.done = st_reg.done;
endmodule : sadc_sar

//--- src/sadc_top.sv
// sadc_top: digital control of an 8-channel, 8-bit successive-approximation converter
// assumes: all pin inputs are synchronous to clk_i; the analog ladder, switch tree and
// comparator sit outside and meet this block through dac_code_o, mux_sel_o and cmp_hi_i
//
// What this block does
// - latch channel bits on rising address strobe, hold until next rise
// - channel value n, C most significant, selects analog input n of 8
// - every conversion runs exactly 8 steps, most significant bit first
// - rising start pulse clears the approximation register
// - approximation starts only on the falling start pulse
// - a new start pulse abandons the running conversion and restarts
// - done flag fed back to start gives free-running conversions
// - done flag falls 0 to 8 conversion clocks after start rises
// - result is positive true, larger input gives larger code
// - first code step at half LSB, then one LSB apart
// - code equals input over reference span times 256
// - result register loads one conversion clock before done rises
`include "sadc_cfg.svh"
module sadc_top (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // host control pins
    input  wire sadc_pkg::sadc_chan_t chan_sel_i,
    input  wire logic              addr_latch_i,
    input  wire logic              conv_start_i,
    input  wire logic              out_en_i,
    // host data and status pins
    output sadc_pkg::sadc_code_t   data_o,
    output logic                   data_oe_o,
    output logic                   conv_done_o,
    // analog front end
    output sadc_pkg::sadc_sel_t    mux_sel_o,
    output sadc_pkg::sadc_code_t   dac_code_o,
    input  wire logic              cmp_hi_i
);
    import sadc_pkg::*;

    localparam sadc_top_st_t ST_RST = '{
        ale_prev: 1'b0,
        sc_prev:  1'b0,
        chan:     `SADC_CHAN_RST,
        state:    ST_IDLE,
        result:   `SADC_CODE_RST,
        eoc:      `SADC_EOC_RST
    };

    sadc_top_st_t st_reg;
    sadc_top_st_t st_next;
    logic         conv_tick;
    logic         ale_rise;
    logic         sc_rise;
    logic         sc_fall;

    sadc_sar_if   sar_if ();

    // =====================================================================
    // conversion clock
    sadc_clkdiv u_clkdiv (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (conv_tick)
    );

    // =====================================================================
    // approximation register
    sadc_sar u_sar (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .sar_if    (sar_if.sar)
    );

    assign sar_if.tick   = conv_tick;
    assign sar_if.cmp_hi = cmp_hi_i;

    // =====================================================================
    // edge detection on the host pins
    assign ale_rise = addr_latch_i & ~st_reg.ale_prev;
    assign sc_rise  = conv_start_i & ~st_reg.sc_prev;
    assign sc_fall  = ~conv_start_i & st_reg.sc_prev;

    // =====================================================================
    // sequencer
    always_comb begin
        st_next          = st_reg;
        sar_if.clear     = 1'b0;
        sar_if.go        = 1'b0;
        st_next.ale_prev = addr_latch_i;
        st_next.sc_prev  = conv_start_i;

        if (ale_rise) begin
            st_next.chan = chan_sel_i;
        end

        if (sc_rise) begin
            sar_if.clear  = 1'b1;
            st_next.eoc   = 1'b0;
            st_next.state = ST_ARMED;
        end else begin
            unique case (st_reg.state)
                ST_IDLE: begin
                    st_next.state = ST_IDLE;
                end
                ST_ARMED: begin
                    if (sc_fall) begin
                        sar_if.go     = 1'b1;
                        st_next.state = ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (sar_if.done) begin
                        st_next.result = sar_if.code;
                        st_next.state  = ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (conv_tick) begin
                        st_next.eoc   = 1'b1;
                        st_next.state = ST_IDLE;
                    end
                end
                default: begin
                    st_next.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================================
    // channel decode, one select line per analog input
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sel
            assign mux_sel_o[g] = (st_reg.chan == sadc_chan_t'(g));
        end
    endgenerate

    // =====================================================================
    // outputs
    // half-LSB offset lives in the ladder; the trial code is plain binary
    // code is the ratio of input to span, scaled by 256
    assign dac_code_o  = sar_if.code;
    assign conv_done_o = st_reg.eoc;
    assign data_o      = st_reg.result;
    assign data_oe_o   = out_en_i;
endmodule : sadc_top
